/* File: bench/owf_chk.sv */
// Checker: port assertions of the output word formatter
`timescale 1ns/1ps
`default_nettype none
module owf_chk (
    // Clock, reset and register port
    input wire logic clock,
    input wire logic reset,
    input wire logic reg_write,
    input wire logic reg_read,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic [7:0] reg_rdata,
    // Streams
    input wire logic conv_valid,
    input wire logic [19:0] conv_data,
    input wire logic conv_ready,
    input wire logic word_valid,
    input wire owf_pkg::owf_word_t word_data,
    input wire logic word_ready,
    input wire logic [1:0] write_protocol_select
);
    // ============================================================
    // Assertions
    default clocking @(posedge clock); endclocking
    default disable iff (reset);
    sequence mid_wr_s;
        reg_write && reg_addr == 8'h15;
    endsequence
    sequence mid_rd_s;
        !reg_write && reg_read && reg_addr == 8'h15;
    endsequence
    mid_readback_a: assert property (mid_wr_s ##1 !reg_write ##1 mid_rd_s |=>
        reg_rdata == $past(reg_wdata, 3)) else $error("middle byte readback wrong");
    ctl_reserved_a: assert property (reg_read && reg_addr == 8'h10 |=>
        reg_rdata[7:4] == 4'h0) else $error("control reserved bits set");
    high_reserved_a: assert property (reg_read && reg_addr == 8'h16 |=>
        reg_rdata[7:4] == 4'h0) else $error("pattern high reserved bits set");
    unmapped_zero_a: assert property (reg_read && reg_addr == 8'h20 |=>
        reg_rdata == 8'h00) else $error("unmapped read not zero");
    rdata_hold_a: assert property (!reg_read |=> $stable(reg_rdata))
        else $error("read data moved without read");
    protocol_write_a: assert property (reg_write && reg_addr == 8'h08 |=>
        write_protocol_select == $past(reg_wdata[1:0])) else $error("protocol not updated");
    full_parity_a: assert property (word_valid |-> word_data[1:0] == 2'h0 ||
        word_data.full_parity_bit == ^word_data.payload) else $error("full parity wrong");
    short_parity_a: assert property (word_valid && word_data.short_parity_bit |->
        word_data.full_parity_bit == ^word_data.payload) else $error("parity off but set");
    word_hold_a: assert property (word_valid && !word_ready |=>
        word_valid && $stable(word_data)) else $error("word dropped before taken");
    word_latency_a: assert property ($rose(word_valid) |->
        $past(conv_valid && conv_ready, 2)) else $error("word without input");
endmodule : owf_chk
bind owf_formatter owf_chk owf_chk_i (.clock, .reset, .reg_write, .reg_read, .reg_addr,
    .reg_wdata, .reg_rdata, .conv_valid, .conv_data, .conv_ready, .word_valid, .word_data,
    .word_ready, .write_protocol_select);
`default_nettype wire

/* File: bench/owf_host.sv */
// Host model: consumes formatted words, promptly, slowly or stalled
`timescale 1ns/1ps
`default_nettype none
module owf_host (
    // Clock, reset and pacing
    input wire logic clock,
    input wire logic reset,
    input wire logic stall,
    input wire logic slow,
    // Word stream
    input wire logic word_valid,
    input wire owf_pkg::owf_word_t word_data,
    output logic word_ready
);
    owf_pkg::owf_word_t got[$];
    logic phase_r;
    // Slow pace takes every other cycle to exercise the hold path
    always_ff @(posedge clock or posedge reset) begin
        if (reset) phase_r <= 1'b0;
        else phase_r <= ~phase_r;
    end
    assign word_ready = !stall && (!slow || phase_r);
    always @(posedge clock) begin
        if (!reset && word_valid && word_ready) got.push_back(word_data);
    end
endmodule : owf_host
`default_nettype wire

/* File: bench/tb_top.sv */
// Testbench: register bank, word formats and buffer of the formatter
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    logic clock = 1'b0;
    logic reset = 1'b1;
    logic reg_write = 1'b0;
    logic reg_read = 1'b0;
    logic conv_valid = 1'b0;
    logic stall = 1'b0;
    logic slow = 1'b0;
    logic [7:0] reg_addr = 8'h00;
    logic [7:0] reg_wdata = 8'h00;
    logic [19:0] conv_data = 20'h00000;
    logic [7:0] reg_rdata;
    logic conv_ready, word_valid, word_ready;
    logic [1:0] write_protocol_select;
    owf_pkg::owf_word_t word_data;
    int err_total = 0;
    int check_count = 0;
    always #50 clock = ~clock;
    owf_formatter owf_formatter_i (.clock, .reset, .reg_write, .reg_read, .reg_addr, .reg_wdata,
        .reg_rdata, .conv_valid, .conv_data, .conv_ready, .word_valid, .word_data,
        .word_ready, .write_protocol_select);
    owf_host owf_host_i (.clock, .reset, .stall, .slow, .word_valid, .word_data, .word_ready);
    // ============================================================
    // Compare, bus and stream tasks
    task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
        check_count++;
        if (got !== exp) begin
            err_total++;
            $display("unexpected at %0t: got %h exp %h", $time, got, exp);
        end
    endtask : chk8
    task automatic chkw(input owf_pkg::owf_word_t got, input owf_pkg::owf_word_t exp);
        check_count++;
        if (got !== exp) begin
            err_total++;
            $display("unexpected at %0t: got %h exp %h", $time, got, exp);
        end
    endtask : chkw
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clock);
        #1 reg_write = 1'b1;
        reg_addr = a;
        reg_wdata = d;
        @(posedge clock);
        #1 reg_write = 1'b0;
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        @(posedge clock);
        #1 reg_read = 1'b1;
        reg_addr = a;
        @(posedge clock);
        #1 reg_read = 1'b0;
        @(posedge clock);
        #1 chk8(reg_rdata, exp);
    endtask : rd
    task automatic send(input logic [19:0] d);
        @(posedge clock);
        #1 conv_valid = 1'b1;
        conv_data = d;
        do @(posedge clock); while (conv_ready !== 1'b1);
        #1 conv_valid = 1'b0;
    endtask : send
    task automatic take(input owf_pkg::owf_word_t exp);
        owf_pkg::owf_word_t w;
        for (int i = 0; i < 60 && owf_host_i.got.size() == 0; i++) @(posedge clock);
        w = (owf_host_i.got.size() > 0) ? owf_host_i.got.pop_front() : 'x;
        chkw(w, exp);
    endtask : take
    function automatic owf_pkg::owf_word_t fmt(input logic [7:0] c, input logic [19:0] d);
        owf_pkg::owf_word_t w;
        logic [19:0] m;
        w.payload = c[0] ? 20'hf5aa5 : d;
        m = ~(20'hfffff >> (4 * (int'(c[3:2]) + 1)));
        w.full_parity_bit = c[1] & ^w.payload;
        w.short_parity_bit = c[1] & ^(w.payload & m);
        return w;
    endfunction : fmt
    // ============================================================
    // Scenarios
    task automatic t_reset();
        rd(8'h10, 8'h00);
        rd(8'h14, 8'h00);
        rd(8'h15, 8'h00);
        rd(8'h16, 8'h00);
        chk8({6'h00, write_protocol_select}, 8'h00);
    endtask : t_reset
    task automatic t_regs();
        wr(8'h10, 8'hff);
        rd(8'h10, 8'h0f);
        wr(8'h16, 8'hff);
        rd(8'h16, 8'h0f);
        wr(8'h14, 8'ha5);
        rd(8'h14, 8'ha5);
        wr(8'h15, 8'h5a);
        rd(8'h15, 8'h5a);
        wr(8'h20, 8'hff);
        rd(8'h20, 8'h00);
        wr(8'h08, 8'h03);
        chk8({6'h00, write_protocol_select}, 8'h03);
    endtask : t_regs
    task automatic t_format();
        logic [7:0] cl [8] = '{8'h00, 8'h02, 8'h06, 8'h0a, 8'h0e, 8'h01, 8'h03, 8'h0f};
        logic [19:0] d;
        for (int i = 0; i < 8; i++) begin
            d = 20'h93c71 ^ 20'(20'h12345 << i);
            wr(8'h10, cl[i]);
            send(d);
            take(fmt(cl[i], d));
        end
    endtask : t_format
    task automatic t_fill();
        wr(8'h10, 8'h02);
        stall = 1'b1;
        for (int i = 0; i < 33; i++) send(20'(i * 7919));
        repeat (2) @(posedge clock);
        #1 chk8({7'h00, conv_ready}, 8'h00);
        slow = 1'b1;
        stall = 1'b0;
        for (int i = 0; i < 33; i++) take(fmt(8'h02, 20'(i * 7919)));
        #1 slow = 1'b0;
    endtask : t_fill
    task automatic summarize();
        if (err_total == 0 && check_count > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask : summarize
    initial begin
        repeat (3) @(posedge clock);
        #1 reset = 1'b0;
        t_reset();
        t_regs();
        t_format();
        t_fill();
        summarize();
    end
    initial begin
        #500000;
        err_total++;
        summarize();
    end
endmodule : tb_top
`default_nettype wire

/* File: verilog/owf_formatter.sv */
// Output word formatter: register bank, word formatting and output FIFO
//
// Contract
// RULE1 - Each output word is 22 bits: 20 payload bits over two parity bits.
// RULE2 - Parity appending off: both low word bits are zero.
// RULE3 - Parity on: bit one is even parity over all twenty payload bits.
// RULE4 - Parity on: bit zero is even parity over leading payload bits only.
// RULE5 - Span field 00/01/10/11 selects 4/8/12/16 leading payload bits for bit zero.
// RULE6 - Source select clear routes conversion result, set routes the fixed pattern.
// RULE7 - Pattern low byte register holds pattern bits 7..0, read/write.
// RULE8 - Pattern middle byte register holds pattern bits 15..8, read/write.
// RULE9 - Pattern high register holds pattern bits 19..16 in bits 3..0.
// RULE10 - Reserved upper bits of control and pattern high registers read zero.
// RULE11 - Reset clears format control: conversion data, no parity, span four.
// RULE12 - Host writes the registers; write protocol select holds clock polarity/phase.
// RULE13 - Fixed pattern is high nibble, middle byte, low byte, high nibble first.
`timescale 1ns/1ps
`default_nettype none

// ============================================================
// Output FIFO with registered output stage
module owf_fifo #(
    parameter int WIDTH = 22,
    parameter int DEPTH = 32
) (
    // Clock and reset
    input wire logic clock,
    input wire logic reset,
    // Fill side
    input wire logic in_valid,
    input wire logic [WIDTH-1:0] in_data,
    output logic in_ready,
    // Drain side
    output logic out_valid,
    output logic [WIDTH-1:0] out_data,
    input wire logic out_ready
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem_r [DEPTH];
    logic [AW-1:0] wr_ptr_r;
    logic [AW-1:0] rd_ptr_r;
    logic [AW:0] count_r;
    logic [AW:0] count_nxt;
    logic in_ready_r;
    logic out_valid_r;
    logic [WIDTH-1:0] out_data_r;
    logic push;
    logic pop;

    assign push = in_valid && in_ready_r;
    // Storage drains into the output stage whenever that stage is free
    assign pop = (count_r != '0) && (!out_valid_r || out_ready);

    always_comb begin
        count_nxt = count_r;
        if (push && !pop) begin
            count_nxt = count_r + (AW+1)'(1);
        end else if (pop && !push) begin
            count_nxt = count_r - (AW+1)'(1);
        end
    end

    always_ff @(posedge clock) begin
        if (push) begin
            mem_r[wr_ptr_r] <= in_data;
        end
    end

    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            wr_ptr_r <= '0;
        end else if (push) begin
            wr_ptr_r <= wr_ptr_r + AW'(1);
        end
    end

    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            rd_ptr_r <= '0;
        end else if (pop) begin
            rd_ptr_r <= rd_ptr_r + AW'(1);
        end
    end

    // Ready comes from the next count, so the fill side sees no combinational path
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            count_r <= '0;
            in_ready_r <= 1'b0;
        end else begin
            count_r <= count_nxt;
            in_ready_r <= (count_nxt != (AW+1)'(DEPTH));
        end
    end

    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            out_valid_r <= 1'b0;
            out_data_r <= '0;
        end else if (pop) begin
            out_valid_r <= 1'b1;
            out_data_r <= mem_r[rd_ptr_r];
        end else if (out_ready) begin
            out_valid_r <= 1'b0;
        end
    end

    assign in_ready = in_ready_r;
    assign out_valid = out_valid_r;
    assign out_data = out_data_r;
endmodule : owf_fifo

// ============================================================
// Top: register bank and formatter
module owf_formatter (
    // Clock and reset
    input wire logic clock,
    input wire logic reset,
    // Register port
    input wire logic reg_write,
    input wire logic reg_read,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    output logic [7:0] reg_rdata,
    // Conversion results
    input wire logic conv_valid,
    input wire logic [19:0] conv_data,
    output logic conv_ready,
    // Formatted output words
    output logic word_valid,
    output owf_pkg::owf_word_t word_data,
    input wire logic word_ready,
    // Configuration seen by the serial link
    output logic [1:0] write_protocol_select
);
    owf_pkg::owf_control_t control_r;
    logic wr_control;
    logic wr_pattern_low;
    logic wr_pattern_middle;
    logic wr_pattern_high;
    logic wr_protocol;
    logic [7:0] pattern_low_value_r;
    logic [7:0] pattern_middle_value_r;
    logic [3:0] pattern_high_value_r;
    logic [1:0] write_protocol_r;
    logic [7:0] rdata_r;
    logic [7:0] rdata_nxt;
    logic [19:0] fixed_test_pattern;
    owf_pkg::owf_word_t word_nxt;
    logic [19:0] span_mask;
    logic fifo_in_ready;
    logic fifo_out_valid;
    owf_pkg::owf_word_t fifo_out_data;

    // ============================================================
    // Register write decode, one strobe per register
    always_comb begin
        wr_control = 1'b0;
        wr_pattern_low = 1'b0;
        wr_pattern_middle = 1'b0;
        wr_pattern_high = 1'b0;
        wr_protocol = 1'b0;
        if (reg_write) begin
            unique case (reg_addr)
                owf_pkg::OWF_ADDR_FORMAT_CONTROL: wr_control = 1'b1;
                owf_pkg::OWF_ADDR_PATTERN_LOW: wr_pattern_low = 1'b1;
                owf_pkg::OWF_ADDR_PATTERN_MIDDLE: wr_pattern_middle = 1'b1;
                owf_pkg::OWF_ADDR_PATTERN_HIGH: wr_pattern_high = 1'b1;
                owf_pkg::OWF_ADDR_WRITE_PROTOCOL: wr_protocol = 1'b1;
                default: begin
                end
            endcase
        end
    end

    // ============================================================
    // Register storage, one process per register
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            control_r.short_parity_span <= owf_pkg::OWF_RESET_SPAN; // RULE11
            control_r.parity_append_enable <= 1'b0;
            control_r.payload_source_select <= 1'b0;
        end else if (wr_control) begin
            control_r.payload_source_select <= reg_wdata[owf_pkg::OWF_SOURCE_BIT];
            control_r.parity_append_enable <= reg_wdata[owf_pkg::OWF_PARITY_EN_BIT];
            control_r.short_parity_span <= reg_wdata[owf_pkg::OWF_SPAN_LSB +: 2];
        end
    end

    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            pattern_low_value_r <= owf_pkg::OWF_RESET_BYTE;
        end else if (wr_pattern_low) begin
            pattern_low_value_r <= reg_wdata; // RULE7
        end
    end

    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            pattern_middle_value_r <= owf_pkg::OWF_RESET_BYTE;
        end else if (wr_pattern_middle) begin
            pattern_middle_value_r <= reg_wdata; // RULE8
        end
    end

    // Only the low nibble is stored; the upper bits cannot hold a stale write
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            pattern_high_value_r <= owf_pkg::OWF_RESET_NIBBLE;
        end else if (wr_pattern_high) begin
            pattern_high_value_r <= reg_wdata[3:0]; // RULE9
        end
    end

    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            write_protocol_r <= owf_pkg::OWF_RESET_PROTOCOL;
        end else if (wr_protocol) begin
            write_protocol_r <= reg_wdata[1:0]; // RULE12
        end
    end

    // ============================================================
    // Register reads, unused bits and unmapped offsets return zero
    always_comb begin
        rdata_nxt = 8'h00;
        unique case (reg_addr)
            owf_pkg::OWF_ADDR_FORMAT_CONTROL: begin
                rdata_nxt[owf_pkg::OWF_SOURCE_BIT] = control_r.payload_source_select;
                rdata_nxt[owf_pkg::OWF_PARITY_EN_BIT] = control_r.parity_append_enable;
                rdata_nxt[owf_pkg::OWF_SPAN_LSB +: 2] = control_r.short_parity_span; // RULE10
            end
            owf_pkg::OWF_ADDR_PATTERN_LOW: begin
                rdata_nxt = pattern_low_value_r;
            end
            owf_pkg::OWF_ADDR_PATTERN_MIDDLE: begin
                rdata_nxt = pattern_middle_value_r;
            end
            owf_pkg::OWF_ADDR_PATTERN_HIGH: begin
                rdata_nxt = {4'h0, pattern_high_value_r}; // RULE10
            end
            owf_pkg::OWF_ADDR_WRITE_PROTOCOL: begin
                rdata_nxt = {6'h00, write_protocol_r};
            end
            default: begin
            end
        endcase
    end

    // Data held after the read so the port never glitches between reads
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            rdata_r <= 8'h00;
        end else if (reg_read) begin
            rdata_r <= rdata_nxt;
        end
    end

    // ============================================================
    // Word formatting
    assign fixed_test_pattern = {pattern_high_value_r, pattern_middle_value_r,
                                 pattern_low_value_r}; // RULE13

    always_comb begin
        span_mask = '0;
        for (int i = 0; i < owf_pkg::OWF_PAYLOAD_W; i++) begin
            // Span covers the top 4 * (field + 1) payload bits
            if (i >= owf_pkg::OWF_PAYLOAD_W - owf_pkg::OWF_SPAN_STEP *
                     (int'(control_r.short_parity_span) + 1)) begin // RULE5
                span_mask[i] = 1'b1;
            end
        end
    end

    always_comb begin
        word_nxt.payload = control_r.payload_source_select ?
                           fixed_test_pattern : conv_data; // RULE6
        word_nxt.full_parity_bit = 1'b0; // RULE2
        word_nxt.short_parity_bit = 1'b0; // RULE2
        if (control_r.parity_append_enable) begin
            word_nxt.full_parity_bit = ^word_nxt.payload; // RULE3
            word_nxt.short_parity_bit = ^(word_nxt.payload & span_mask); // RULE4
        end
    end

    // Format is taken at push; later control writes do not touch buffered words
    owf_fifo #(
        .WIDTH(owf_pkg::OWF_WORD_W),
        .DEPTH(owf_pkg::OWF_FIFO_DEPTH)
    ) u_fifo (
        .clock(clock),
        .reset(reset),
        .in_valid(conv_valid),
        .in_data(word_nxt), // RULE1
        .in_ready(fifo_in_ready),
        .out_valid(fifo_out_valid),
        .out_data(fifo_out_data),
        .out_ready(word_ready)
    );

    assign conv_ready = fifo_in_ready;
    assign word_valid = fifo_out_valid;
    assign word_data = fifo_out_data;
    assign reg_rdata = rdata_r;
    assign write_protocol_select = write_protocol_r;
endmodule : owf_formatter
`default_nettype wire

/* File: verilog/owf_pkg.sv */
// Package: register map, field layout and types of the output word formatter
`default_nettype none
package owf_pkg;
    // ============================================================
    // Register offsets
    localparam logic [7:0] OWF_ADDR_WRITE_PROTOCOL = 8'h08;
    localparam logic [7:0] OWF_ADDR_FORMAT_CONTROL = 8'h10;
    localparam logic [7:0] OWF_ADDR_PATTERN_LOW = 8'h14;
    localparam logic [7:0] OWF_ADDR_PATTERN_MIDDLE = 8'h15;
    localparam logic [7:0] OWF_ADDR_PATTERN_HIGH = 8'h16;

    // ============================================================
    // Field positions of the format control register
    localparam int OWF_SOURCE_BIT = 0;
    localparam int OWF_PARITY_EN_BIT = 1;
    localparam int OWF_SPAN_LSB = 2;

    // ============================================================
    // Reset values
    localparam logic [7:0] OWF_RESET_BYTE = 8'h00;
    localparam logic [1:0] OWF_RESET_SPAN = 2'h0;
    localparam logic [1:0] OWF_RESET_PROTOCOL = 2'h0;
    localparam logic [3:0] OWF_RESET_NIBBLE = 4'h0;

    // ============================================================
    // Widths and buffer depth
    localparam int OWF_PAYLOAD_W = 20;
    localparam int OWF_WORD_W = 22;
    localparam int OWF_FIFO_DEPTH = 32;
    localparam int OWF_SPAN_STEP = 4;

    // ============================================================
    // Types
    typedef struct packed {
        logic [1:0] short_parity_span;
        logic parity_append_enable;
        logic payload_source_select;
    } owf_control_t;

    typedef struct packed {
        logic [19:0] payload;
        logic full_parity_bit;
        logic short_parity_bit;
    } owf_word_t;
endpackage : owf_pkg
`default_nettype wire
